// ### rtl/hss_pkg.sv
// Shared constants for the high-side switch controller: register map,
// field layout, configuration codes, power modes and timing counts.
// Assumes a 250 MHz core clock.
package hss_pkg;

    // ============================================================
    // Clock and timing
    localparam int CLK_HZ          = 250_000_000;
    localparam int PWM_STEPS       = 256;
    localparam int PWM_LO_HZ       = 200;
    localparam int PWM_HI_HZ       = 400;
    localparam int PWM_HI_DIV      = PWM_HI_HZ / PWM_LO_HZ;
    // Cycles per duty step at the low frequency (longest, rounds down)
    localparam int PWM_STEP_LO_CYC = CLK_HZ / (PWM_LO_HZ * PWM_STEPS);
    localparam int OC_FILT_NS      = 16000;
    // Over-current filter as a least time, rounded up
    localparam int OC_FILT_CYC     = (OC_FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int OC_CNT_W        = $clog2(OC_FILT_CYC + 1);

    // ============================================================
    // Register byte offsets
    localparam logic [7:0] OFF_CFG_A  = 8'h00;
    localparam logic [7:0] OFF_CFG_B  = 8'h04;
    localparam logic [7:0] OFF_OC_ST  = 8'h08;
    localparam logic [7:0] OFF_OL_ST  = 8'h0c;
    localparam logic [7:0] OFF_DUTY1  = 8'h10;
    localparam logic [7:0] OFF_DUTY2  = 8'h14;
    localparam logic [7:0] OFF_FREQ   = 8'h18;
    localparam logic [7:0] OFF_SCTL   = 8'h1c;
    localparam logic [7:0] OFF_SST    = 8'h20;

    // ============================================================
    // Fields
    localparam int NUM_HS     = 4;
    localparam int CFG_W      = 3;
    localparam int CFG_LO_POS = 0;
    localparam int CFG_HI_POS = 4;
    localparam int SC_OV_DIS  = 0;
    localparam int SC_UV_DIS  = 1;
    localparam int SC_REC     = 2;
    localparam int SS_OV      = 0;
    localparam int SS_UV      = 1;

    // Output source codes
    localparam logic [2:0] CFG_OFF  = 3'h0;
    localparam logic [2:0] CFG_ON   = 3'h1;
    localparam logic [2:0] CFG_TMR1 = 3'h2;
    localparam logic [2:0] CFG_TMR2 = 3'h3;
    localparam logic [2:0] CFG_PWM1 = 3'h4;
    localparam logic [2:0] CFG_PWM2 = 3'h5;

    // Device power modes on mode_i
    localparam logic [2:0] MODE_NORMAL   = 3'h0;
    localparam logic [2:0] MODE_STOP     = 3'h1;
    localparam logic [2:0] MODE_SLEEP    = 3'h2;
    localparam logic [2:0] MODE_RESTART  = 3'h3;
    localparam logic [2:0] MODE_FAILSAFE = 3'h4;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : hss_pkg

// ### rtl/hss_pwm_if.sv
// Link between the controller and one pulse generator.
// Assumes both ends share clk_i.
`timescale 1ns/1ps
interface hss_pwm_if;
    logic [7:0] duty;   // Duty setting, high time = duty/256
    logic       fast;   // 1 selects the higher frequency
    logic       ce;     // Clock enable
    logic       wave;   // Generated waveform

    modport gen (input duty, input fast, input ce, output wave);
    modport ctl (output duty, output fast, output ce, input wave);
endinterface : hss_pwm_if

// ### rtl/hss_pwm.sv
// One 8-bit pulse generator with two selectable frequencies.
// Assumes a synchronised active-low reset from the top.
`timescale 1ns/1ps
module hss_pwm #(
    parameter int STEP_LO_CYC = hss_pkg::PWM_STEP_LO_CYC   // Cycles per step at low rate
) (
    input  wire logic clk_i,    // Core clock
    input  wire logic rst_ni,   // Synchronised reset, active low
    hss_pwm_if.gen    pif       // Settings in, waveform out
);
    localparam int PW = $clog2(STEP_LO_CYC + 1);
    localparam logic [PW-1:0] LIM_LO = PW'(STEP_LO_CYC - 1);
    localparam logic [PW-1:0] LIM_HI = PW'(STEP_LO_CYC / hss_pkg::PWM_HI_DIV - 1);

    // ============================================================
    // Parameter check
    if (STEP_LO_CYC < 2 * hss_pkg::PWM_HI_DIV) begin : g_bad_step
        $error("hss_pwm: STEP_LO_CYC too small");
    end

    typedef struct packed {
        logic [PW-1:0] presc;
        logic [7:0]    phase;
        logic          wave;
    } hss_pwm_state_t;

    hss_pwm_state_t s;
    hss_pwm_state_t n;
    logic [PW-1:0]  lim;

    // ============================================================
    // Prescaler, free-running phase, compare
    always_comb begin
        n   = s;
        lim = pif.fast ? LIM_HI : LIM_LO;
        // Compare with >= so a rate change mid-step never overruns
        if (s.presc >= lim) begin
            n.presc = '0;
            n.phase = s.phase + 8'h01;
        end else begin
            n.presc = s.presc + PW'(1);
        end
        // No restart on assignment: the wave is always live
        n.wave = (s.phase < pif.duty);
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            s <= '0;
        end else if (pif.ce) begin
            s <= n;
        end
    end

    assign pif.wave = s.wave;

endmodule : hss_pwm

// ### rtl/hss_top.sv
// High-side switch controller: four outputs, two pulse generators,
// supply and over-current shutdown, open-load flags, AXI4-Lite registers.
// Assumes comparator, timer and mode inputs synchronous to clk_i.
`timescale 1ns/1ps

// Contract
// - Each output is driven by its register, a timer, or a pulse generator.
// - Output configuration writable only in normal mode; held in stop and sleep.
// - Entering restart or fail-safe switches every output off.
// - Supply over-voltage turns outputs off unless its disable bit is set.
// - Supply under-voltage turns outputs off unless its disable bit is set.
// - On fault release, recovery bit 1 restores outputs; 0 clears configuration.
// - Supply faults set only their own two status flags.
// - Over-current longer than filter time switches output off, sets its flag.
// - Over-current shutdown resets that output configuration to 000.
// - Low load current while on sets open-load flag; output stays on.
// - Open-load flags stay set until software clears them.
// - Open-load, over-current and supply shutdown stay active in stop and sleep.
// - After restart or fail-safe, register writes can re-enable outputs.
// - Two pulse generators, each with its own 8-bit duty.
// - Each generator selects 200 Hz or 400 Hz independently.
// - Pulse output starts as soon as an output is assigned to a generator.
// - Any output may use timer 1, timer 2, generator 1 or generator 2.
module hss_top #(
    parameter int ADDR_W      = 8,                          // AXI address width
    parameter int PWM_STEP_CYC = hss_pkg::PWM_STEP_LO_CYC   // Cycles per step at 200 Hz
) (
    input  wire logic              clk_i,          // Core clock
    input  wire logic              rstn_i,         // Async reset, active low
    input  wire logic              ce_i,           // Clock enable, freezes state
    input  wire logic [2:0]        mode_i,         // Device power mode
    input  wire logic              ov_i,           // Switch supply above limit
    input  wire logic              uv_i,           // Switch supply below limit
    input  wire logic [3:0]        oc_i,           // Load current above limit
    input  wire logic [3:0]        ol_i,           // Load current below open-load level
    input  wire logic              timer1_i,       // Internal timer 1 level
    input  wire logic              timer2_i,       // Internal timer 2 level
    output logic      [3:0]        hs_on_o,        // Output switch drive
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // Write address
    input  wire logic              s_axi_awvalid,  // Write address valid
    output logic                   s_axi_awready,  // Write address ready
    input  wire logic [31:0]       s_axi_wdata,    // Write data
    input  wire logic [3:0]        s_axi_wstrb,    // Write strobes
    input  wire logic              s_axi_wvalid,   // Write data valid
    output logic                   s_axi_wready,   // Write data ready
    output logic      [1:0]        s_axi_bresp,    // Write response
    output logic                   s_axi_bvalid,   // Write response valid
    input  wire logic              s_axi_bready,   // Write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,   // Read address
    input  wire logic              s_axi_arvalid,  // Read address valid
    output logic                   s_axi_arready,  // Read address ready
    output logic      [31:0]       s_axi_rdata,    // Read data
    output logic      [1:0]        s_axi_rresp,    // Read response
    output logic                   s_axi_rvalid,   // Read data valid
    input  wire logic              s_axi_rready    // Read data ready
);
    localparam int OCW = hss_pkg::OC_CNT_W;
    localparam logic [OCW-1:0] OC_LIM = OCW'(hss_pkg::OC_FILT_CYC);
    localparam logic [ADDR_W-1:0] A_CFG_A = ADDR_W'(hss_pkg::OFF_CFG_A);
    localparam logic [ADDR_W-1:0] A_CFG_B = ADDR_W'(hss_pkg::OFF_CFG_B);
    localparam logic [ADDR_W-1:0] A_OC_ST = ADDR_W'(hss_pkg::OFF_OC_ST);
    localparam logic [ADDR_W-1:0] A_OL_ST = ADDR_W'(hss_pkg::OFF_OL_ST);
    localparam logic [ADDR_W-1:0] A_DUTY1 = ADDR_W'(hss_pkg::OFF_DUTY1);
    localparam logic [ADDR_W-1:0] A_DUTY2 = ADDR_W'(hss_pkg::OFF_DUTY2);
    localparam logic [ADDR_W-1:0] A_FREQ  = ADDR_W'(hss_pkg::OFF_FREQ);
    localparam logic [ADDR_W-1:0] A_SCTL  = ADDR_W'(hss_pkg::OFF_SCTL);
    localparam logic [ADDR_W-1:0] A_SST   = ADDR_W'(hss_pkg::OFF_SST);

    // ============================================================
    // Parameter check
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
        $error("hss_top: ADDR_W must be 6 to 32");
    end

    typedef struct packed {
        logic [3:0][2:0]     cfg;        // Per-output source select
        logic [3:0]          oc_flag;    // Sticky over-current flags
        logic [3:0]          ol_flag;    // Sticky open-load flags
        logic [7:0]          duty1;
        logic [7:0]          duty2;
        logic [1:0]          freq;       // Bit per generator, 1 = fast
        logic [2:0]          sctl;       // Supply shutdown control
        logic [1:0]          sflag;      // Sticky supply flags
        logic                fault_prev;
        logic [3:0][OCW-1:0] oc_cnt;
        logic [3:0]          hs_on;
        logic                aw_got;
        logic                w_got;
        logic [ADDR_W-1:0]   awaddr;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
    } hss_state_t;

    hss_state_t s;
    hss_state_t n;
    logic [1:0] rst_sync;
    logic       rst_n;
    logic       fault;
    logic       off_mode;
    logic       normal;
    logic       do_wr;
    logic       wb;
    logic [7:0] wd;
    logic [3:0] oc_clr;
    logic [3:0] ol_clr;
    logic [1:0] ss_clr;
    logic [3:0] oc_set;
    logic [3:0] ol_set;
    logic       src;

    hss_pwm_if pif1 ();
    hss_pwm_if pif2 ();

    // ============================================================
    // Address decode, shared by read and write paths
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        case (a)
            A_CFG_A, A_CFG_B, A_OC_ST, A_OL_ST, A_DUTY1,
            A_DUTY2, A_FREQ, A_SCTL, A_SST: is_mapped = 1'b1;
            default:                        is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // Read view of the register file; unused bits read zero
    function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                              input hss_state_t st);
        read_word = 32'h0;
        case (a)
            A_CFG_A: read_word[7:0] = {1'b0, st.cfg[1], 1'b0, st.cfg[0]};
            A_CFG_B: read_word[7:0] = {1'b0, st.cfg[3], 1'b0, st.cfg[2]};
            A_OC_ST: read_word[3:0] = st.oc_flag;
            A_OL_ST: read_word[3:0] = st.ol_flag;
            A_DUTY1: read_word[7:0] = st.duty1;
            A_DUTY2: read_word[7:0] = st.duty2;
            A_FREQ:  read_word[1:0] = st.freq;
            A_SCTL:  read_word[2:0] = st.sctl;
            A_SST:   read_word[1:0] = st.sflag;
            default: read_word = 32'h0;
        endcase
    endfunction : read_word

    // ============================================================
    // Reset release through two flops
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ============================================================
    // Pulse generators
    assign pif1.duty = s.duty1;
    assign pif1.fast = s.freq[0];
    assign pif1.ce   = ce_i;
    assign pif2.duty = s.duty2;
    assign pif2.fast = s.freq[1];
    assign pif2.ce   = ce_i;

    hss_pwm #(.STEP_LO_CYC(PWM_STEP_CYC)) u_pwm1 (
        .clk_i  (clk_i),
        .rst_ni (rst_n),
        .pif    (pif1.gen)
    );

    hss_pwm #(.STEP_LO_CYC(PWM_STEP_CYC)) u_pwm2 (
        .clk_i  (clk_i),
        .rst_ni (rst_n),
        .pif    (pif2.gen)
    );

    // ============================================================
    // Next-state logic: bus slave, register writes, protection, drive
    always_comb begin
        n        = s;
        src      = 1'b0;
        oc_set   = 4'h0;
        ol_set   = 4'h0;
        normal   = (mode_i == hss_pkg::MODE_NORMAL);
        off_mode = (mode_i == hss_pkg::MODE_RESTART) ||
                   (mode_i == hss_pkg::MODE_FAILSAFE);
        // Disable bits mask the shutdown only, never the flags
        fault    = (ov_i && !s.sctl[hss_pkg::SC_OV_DIS]) ||
                   (uv_i && !s.sctl[hss_pkg::SC_UV_DIS]);

        // Write address and data may arrive in either order
        if (s_axi_awvalid && s.awready) begin
            n.aw_got = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        do_wr  = s.aw_got && s.w_got && !s.bvalid;
        // All fields live in byte lane 0
        wb     = do_wr && s.wstrb[0];
        wd     = s.wdata[7:0];
        oc_clr = 4'h0;
        ol_clr = 4'h0;
        ss_clr = 2'h0;
        if (do_wr) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = is_mapped(s.awaddr) ? hss_pkg::RESP_OKAY : hss_pkg::RESP_SLVERR;
        end
        if (wb) begin
            case (s.awaddr)
                // Configuration frozen outside normal mode
                A_CFG_A: if (normal) begin
                    n.cfg[0] = wd[hss_pkg::CFG_LO_POS +: hss_pkg::CFG_W];
                    n.cfg[1] = wd[hss_pkg::CFG_HI_POS +: hss_pkg::CFG_W];
                end
                A_CFG_B: if (normal) begin
                    n.cfg[2] = wd[hss_pkg::CFG_LO_POS +: hss_pkg::CFG_W];
                    n.cfg[3] = wd[hss_pkg::CFG_HI_POS +: hss_pkg::CFG_W];
                end
                A_DUTY1: if (normal) n.duty1 = wd;
                A_DUTY2: if (normal) n.duty2 = wd;
                A_FREQ:  if (normal) n.freq = wd[1:0];
                A_SCTL:  n.sctl = wd[2:0];
                A_OC_ST: oc_clr = wd[3:0];
                A_OL_ST: ol_clr = wd[3:0];
                A_SST:   ss_clr = wd[1:0];
                default: ;
            endcase
        end

        // Held off with an empty configuration until rewritten
        if (off_mode) begin
            n.cfg = '0;
        end
        // Fault release without recovery drops the configuration
        if (s.fault_prev && !fault && !s.sctl[hss_pkg::SC_REC]) begin
            n.cfg = '0;
        end
        n.fault_prev = fault;

        // Per-output protection; active in every mode
        for (int i = 0; i < hss_pkg::NUM_HS; i++) begin
            if (s.hs_on[i] && oc_i[i]) begin
                if (s.oc_cnt[i] == OC_LIM) begin
                    oc_set[i]   = 1'b1;
                    n.cfg[i]    = hss_pkg::CFG_OFF;
                    n.oc_cnt[i] = '0;
                end else begin
                    n.oc_cnt[i] = s.oc_cnt[i] + OCW'(1);
                end
            end else begin
                n.oc_cnt[i] = '0;
            end
            // Flag only, the output stays driven
            ol_set[i] = s.hs_on[i] && ol_i[i];

            case (n.cfg[i])
                hss_pkg::CFG_ON:   src = 1'b1;
                hss_pkg::CFG_TMR1: src = timer1_i;
                hss_pkg::CFG_TMR2: src = timer2_i;
                hss_pkg::CFG_PWM1: src = pif1.wave;
                hss_pkg::CFG_PWM2: src = pif2.wave;
                default:           src = 1'b0;
            endcase
            // Recovery comes back through the held configuration
            n.hs_on[i] = src && !fault && !off_mode;
        end

        // Sticky flags: a new event wins over a same-cycle clear
        n.oc_flag = (s.oc_flag & ~oc_clr) | oc_set;
        n.ol_flag = (s.ol_flag & ~ol_clr) | ol_set;
        n.sflag   = (s.sflag & ~ss_clr) | {uv_i, ov_i};

        // Read channel, one outstanding read
        if (s_axi_arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rdata  = read_word(s_axi_araddr, s);
            n.rresp  = is_mapped(s_axi_araddr) ? hss_pkg::RESP_OKAY : hss_pkg::RESP_SLVERR;
        end else if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end

        // Readies registered from the next state so outputs stay flop-driven
        n.arready = !n.rvalid;
        n.awready = !n.aw_got && !n.bvalid;
        n.wready  = !n.w_got && !n.bvalid;
    end

    // State register, frozen while ce_i is low
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else if (ce_i) begin
            s <= n;
        end
    end

    // ============================================================
    // Outputs
    assign hs_on_o       = s.hs_on;
    assign s_axi_awready = s.awready;
    assign s_axi_wready  = s.wready;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;

endmodule : hss_top

// ### tb/hss_monitor.sv
// Port checker for hss_top: shutdown and register bus timing.
// Assumes it is bound into hss_top.
`timescale 1ns/1ps
module hss_monitor #(
    parameter int ADDR_W = 8  // Address width
) (
    input wire logic              clk_i,          // Clock
    input wire logic              rstn_i,         // Reset, low
    input wire logic              ce_i,           // Enable
    input wire logic [2:0]        mode_i,         // Mode
    input wire logic [3:0]        oc_i,           // Over-current
    input wire logic [3:0]        hs_on_o,        // Drive
    input wire logic              s_axi_awvalid,  // AW valid
    input wire logic              s_axi_awready,  // AW ready
    input wire logic              s_axi_wvalid,   // W valid
    input wire logic              s_axi_wready,   // W ready
    input wire logic              s_axi_bvalid,   // B valid
    input wire logic              s_axi_bready,   // B ready
    input wire logic [ADDR_W-1:0] s_axi_araddr,   // AR address
    input wire logic              s_axi_arvalid,  // AR valid
    input wire logic              s_axi_arready,  // AR ready
    input wire logic              s_axi_rvalid,   // R valid
    input wire logic              s_axi_rready,   // R ready
    input wire logic [1:0]        s_axi_rresp     // R response
);
    // ============================================================
    // Over-current run length on output one
    localparam int OCMAX = hss_pkg::OC_FILT_CYC + 2;
    logic [12:0] oc_cnt_reg;
    logic [12:0] oc_cnt_next;
    // Counter restarts when the drive or the comparator drops
    always_comb oc_cnt_next = (oc_i[0] && hs_on_o[0]) ? oc_cnt_reg + 13'h1 : 13'h0;
    always_ff @(posedge clk_i or negedge rstn_i)
        if (!rstn_i) oc_cnt_reg <= 13'h0;
        else if (ce_i) oc_cnt_reg <= oc_cnt_next;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    mode_off_a: assert property (ce_i && mode_i inside {3'h3, 3'h4} |=> hs_on_o == 4'h0)
        else $error("output on in restart");
    oc_filt_a: assert property (oc_cnt_reg <= OCMAX)
        else $error("over-current not cut");
    wr_answer_a: assert property (ce_i && s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("no write answer");
    rd_answer_a: assert property (ce_i && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    b_drop_a: assert property (ce_i && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stuck");
    r_drop_a: assert property (ce_i && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid stuck");
    rd_excl_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read");
    rd_unmapped_a: assert property (ce_i && s_axi_arvalid && s_axi_arready
        && s_axi_araddr > 'h20 |=> s_axi_rresp == hss_pkg::RESP_SLVERR) else $error("bad rresp");
    cover property (oc_cnt_reg == 13'(hss_pkg::OC_FILT_CYC));
    cover property (hs_on_o[0] && mode_i == hss_pkg::MODE_RESTART);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule : hss_monitor
bind hss_top hss_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

// ### tb/hss_load.sv
// Four loads on the switch outputs with comparator levels.
// Assumes drive levels straight from hss_top.
`timescale 1ns/1ps
module hss_load (
    input  wire logic [3:0] hs_on_i,  // Switch drive
    input  wire logic [3:0] short_i,  // Load shorted
    input  wire logic [3:0] open_i,   // Load missing
    output logic      [3:0] oc_o,     // Over-current level
    output logic      [3:0] ol_o      // Low-current level
);
    // ============================================================
    // An unpowered load draws nothing, so its low-current level is high
    assign oc_o = hs_on_i & short_i;
    assign ol_o = open_i | ~hs_on_i;
endmodule : hss_load

// ### tb/high_side_switch_control_tb.sv
// Self-checking bench for hss_top with loads on its outputs.
// Assumes hss_pkg, hss_top, hss_load and the checker are compiled.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module high_side_switch_control_tb;
    // ============================================================
    // Signals
    localparam int STEP = 8;  // Short step keeps a period at 2048 cycles
    typedef struct packed {logic [2:0] c; logic t1; logic t2; logic e;} hss_row_t;
    hss_row_t    rows [7] = '{'{3'h1,1'h0,1'h0,1'h1}, '{3'h2,1'h1,1'h0,1'h1},
        '{3'h2,1'h0,1'h1,1'h0}, '{3'h3,1'h0,1'h1,1'h1}, '{3'h3,1'h1,1'h0,1'h0},
        '{3'h0,1'h1,1'h1,1'h0}, '{3'h6,1'h1,1'h1,1'h0}};
    logic        clk_i, rstn_i, ce_i, ov_i, uv_i, t1, t2;
    logic        awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
    logic [2:0]  mode_i;
    logic [3:0]  oc, ol, hs, sh, op, ws;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd_d;
    logic [1:0]  bresp, rresp;
    int          num_errors, checks_done, cyc, n, hi1, hi2;
    hss_top #(.PWM_STEP_CYC(STEP)) u_dut (.clk_i, .rstn_i, .ce_i,
        .mode_i, .ov_i, .uv_i, .oc_i(oc), .ol_i(ol), .timer1_i(t1),
        .timer2_i(t2), .hs_on_o(hs), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
    hss_load u_load (.hs_on_i(hs), .short_i(sh), .open_i(op), .oc_o(oc), .ol_o(ol));
    // ============================================================
    // Bus tasks: bready and rready stay high, so each answer is taken at once
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        {awa, wd, awv, wv} <= {a, v, 2'h3};
        do begin
            @(posedge clk_i);
            if (awv && awr) awv <= 1'h0;
            if (wv && wr_r) wv <= 1'h0;
        end while (!bv);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        ara <= a;
        arv <= 1'h1;
        do begin
            @(posedge clk_i);
            if (arr) arv <= 1'h0;
        end while (!rv);
    endtask : rd
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    initial begin
        clk_i = 1'h0;
        forever #2 clk_i = ~clk_i;
    end
    // Hang guard, far past the expected 6200 or so cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin num_errors++; finish_test(); end
    end
    // ============================================================
    // Main sequence
    initial begin
        {ce_i, br, rr, ws} = 7'h7f;
        {rstn_i, ov_i, uv_i, t1, t2, awv, wv, arv, mode_i, sh, op, awa, ara, wd} = '0;
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'h1;
        `CHK("hs_reset", 4'h0, hs)
        rd(8'h40);
        `CHK("unmapped", 32'h0, rd_d)
        wr(8'h40, 32'h1);
        `CHK("bresp", hss_pkg::RESP_SLVERR, bresp)
        foreach (rows[i]) begin
            {t1, t2} <= {rows[i].t1, rows[i].t2};
            wr(hss_pkg::OFF_CFG_A, {29'h0, rows[i].c});
            repeat (2) @(posedge clk_i);
            `CHK("row_out", rows[i].e, hs[0])
        end
        $display("source rows done");
        wr(hss_pkg::OFF_CFG_A, 32'h1);
        mode_i <= hss_pkg::MODE_STOP;
        wr(hss_pkg::OFF_CFG_A, 32'h0);
        rd(hss_pkg::OFF_CFG_A);
        `CHK("cfg_held", 32'h1, rd_d)
        wr(hss_pkg::OFF_SCTL, 32'h4);
        ov_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        `CHK("ov_off", 1'h0, hs[0])
        rd(hss_pkg::OFF_SST);
        `CHK("sst", 32'h1, rd_d)
        rd(hss_pkg::OFF_OC_ST);
        `CHK("oc_clean", 32'h0, rd_d)
        ov_i <= 1'h0;
        repeat (3) @(posedge clk_i);
        `CHK("recover", 1'h1, hs[0])
        wr(hss_pkg::OFF_SCTL, 32'h0);
        uv_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        `CHK("uv_off", 1'h0, hs[0])
        uv_i <= 1'h0;
        @(posedge clk_i);
        rd(hss_pkg::OFF_CFG_A);
        `CHK("no_recover", {1'h0, 32'h0}, {hs[0], rd_d})
        $display("supply test done");
        mode_i <= hss_pkg::MODE_NORMAL;
        wr(hss_pkg::OFF_CFG_A, 32'h1);
        mode_i <= hss_pkg::MODE_RESTART;
        repeat (3) @(posedge clk_i);
        `CHK("restart_off", 1'h0, hs[0])
        mode_i <= hss_pkg::MODE_NORMAL;
        wr(hss_pkg::OFF_CFG_A, 32'h1);
        repeat (2) @(posedge clk_i);
        `CHK("reenable", 1'h1, hs[0])
        sh[0] <= 1'h1;
        n = 0;
        while (hs[0] && n < 5000) begin @(posedge clk_i); n++; end
        `CHK("oc_wait", 1'h1, n > hss_pkg::OC_FILT_CYC && n < 5000)
        sh[0] <= 1'h0;
        rd(hss_pkg::OFF_OC_ST);
        `CHK("oc_flag", 32'h1, rd_d)
        rd(hss_pkg::OFF_CFG_A);
        `CHK("oc_cfg", 32'h0, rd_d)
        wr(hss_pkg::OFF_OC_ST, 32'h1);
        wr(hss_pkg::OFF_CFG_A, 32'h1);
        op[0] <= 1'h1;
        repeat (3) @(posedge clk_i);
        `CHK("ol_stay", 1'h1, hs[0])
        op[0] <= 1'h0;
        rd(hss_pkg::OFF_OL_ST);
        `CHK("ol_sticky", 32'h1, rd_d)
        wr(hss_pkg::OFF_OL_ST, 32'h1);
        rd(hss_pkg::OFF_OL_ST);
        `CHK("ol_clear", 32'h0, rd_d)
        $display("protection test done");
        wr(hss_pkg::OFF_DUTY1, 32'h80);
        wr(hss_pkg::OFF_DUTY2, 32'h40);
        wr(hss_pkg::OFF_FREQ, 32'h2);
        wr(hss_pkg::OFF_CFG_A, 32'h54);
        repeat (4) @(posedge clk_i);
        {hi1, hi2} = '0;
        repeat (256 * STEP) begin @(posedge clk_i); hi1 += hs[0]; hi2 += hs[1]; end
        `CHK("pwm_slow", 128 * STEP, hi1)
        `CHK("pwm_fast", 2 * 64 * (STEP / 2), hi2)
        $display("pulse test done");
        finish_test();
    end
endmodule : high_side_switch_control_tb
